// ===== vapf_pkg.sv
// constants and types of the vbi ancillary packet formatter
`default_nettype none
package vapf_pkg;

  // ****************************************
  // packet layout
  // ****************************************
  localparam logic [7:0] VAPF_ADF_FIRST = 8'h00;
  localparam logic [7:0] VAPF_ADF_NEXT = 8'hff;
  localparam logic [1:0] VAPF_ADF_LAST_IDX = 2'h2;
  localparam int VAPF_MAX_ANC = 100;
  localparam int VAPF_OVERHEAD = 7;
  localparam int VAPF_MAX_UDW = ((VAPF_MAX_ANC - VAPF_OVERHEAD) / 4) * 4;
  localparam logic [5:0] VAPF_DID_RESET = 6'h01;
  localparam logic [7:0] VAPF_FILLER = 8'h80;
  localparam logic [6:0] VAPF_TTX625_BYTES = 7'h28;
  localparam logic [6:0] VAPF_TTX525_BYTES = 7'h20;

  // ****************************************
  // format id bytes
  // ****************************************
  localparam logic [7:0] VAPF_SDID_WSS = 8'h41;
  localparam logic [7:0] VAPF_SDID_UNUSED = 8'h42;
  localparam logic [7:0] VAPF_SDID_VPS = 8'h83;
  localparam logic [7:0] VAPF_SDID_CC_F2 = 8'h44;
  localparam logic [7:0] VAPF_SDID_CC_F1 = 8'h85;
  localparam logic [7:0] VAPF_SDID_GD_F2 = 8'h86;
  localparam logic [7:0] VAPF_SDID_GD_F1 = 8'h47;
  localparam logic [7:0] VAPF_SDID_T625_F2 = 8'h48;
  localparam logic [7:0] VAPF_SDID_T625_F1 = 8'h89;
  localparam logic [7:0] VAPF_SDID_T625C_F2 = 8'h8a;
  localparam logic [7:0] VAPF_SDID_T625C_F1 = 8'h4b;
  localparam logic [7:0] VAPF_SDID_T525_F2 = 8'h50;
  localparam logic [7:0] VAPF_SDID_T525_F1 = 8'h91;
  localparam logic [7:0] VAPF_SDID_T525C_F2 = 8'h92;
  localparam logic [7:0] VAPF_SDID_T525C_F1 = 8'h53;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0]
  {
    VAPF_FMT_WSS = 3'h0,
    VAPF_FMT_VPS = 3'h1,
    VAPF_FMT_CC = 3'h2,
    VAPF_FMT_GUIDE = 3'h3,
    VAPF_FMT_TTX625 = 3'h4,
    VAPF_FMT_TTX525 = 3'h5
  } vapf_fmt_type;

  typedef struct packed
  {
    vapf_fmt_type fmt;
    logic field2;
    logic custom;
    logic [9:0] tv_line;
    logic [2:0] magazine;
    logic [4:0] page;
    logic [6:0] nbytes;
  } vapf_desc_type;

  typedef struct packed
  {
    logic [7:0] data;
    logic first;
    logic last;
  } vapf_word_type;

  // 6-bit value with even parity in bit 6 and its inverse in bit 7
  function automatic logic [7:0] vapf_protect(input logic [5:0] v);
    vapf_protect = {~(^v), ^v, v};
  endfunction : vapf_protect

endpackage : vapf_pkg
`default_nettype wire

// ===== vapf_skid.sv
// two-entry buffer between the packet sequencer and the output fifo
`timescale 1ns/100ps
`default_nettype none
module vapf_skid
#(
  parameter int WIDTH = 10,
  parameter int DEPTH = 2
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // storage needs no reset; valid is carried by count
  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

endmodule : vapf_skid
`default_nettype wire

// ===== vapf_formatter.sv
// ancillary packet sequencer: one packet per sliced line, emitted after eav
`timescale 1ns/100ps
`default_nettype none
module vapf_formatter
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // control field of vbi_control_one
  input wire logic [5:0] slicer_data_id_field,
  // per-line descriptor from the slicer
  input wire logic desc_valid,
  output logic desc_ready,
  input wire vapf_pkg::vapf_desc_type desc,
  // decoded bytes of that line, in slicer order
  input wire logic byte_valid,
  output logic byte_ready,
  input wire logic [7:0] byte_data,
  // video timing of the output stream
  input wire logic eav_pulse,
  input wire logic [9:0] eav_line,
  // words toward the output fifo
  output logic anc_valid,
  input wire logic anc_ready,
  output logic [7:0] anc_data,
  output logic anc_first,
  output logic anc_last,
  // status
  output logic busy
);
  import vapf_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  typedef enum logic [11:0]
  {
    S_IDLE = 12'h001,
    S_WAIT = 12'h002,
    S_ADF = 12'h004,
    S_DID = 12'h008,
    S_SDID = 12'h010,
    S_DC = 12'h020,
    S_LEAD = 12'h040,
    S_LO = 12'h080,
    S_HI = 12'h100,
    S_FILL = 12'h200,
    S_CS = 12'h400,
    S_DRAIN = 12'h800
  } vapf_state_type;

  vapf_state_type state;
  vapf_state_type next_state;
  vapf_desc_type line;
  logic [5:0] did_field;
  logic [1:0] idx;
  logic [6:0] bytes_left;
  logic [6:0] drain_left;
  logic [1:0] fill_left;
  logic [5:0] groups;
  logic [3:0] hi_nibble;
  logic [6:0] csum;
  logic lead;
  vapf_word_type word;
  logic word_valid;
  logic buf_ready;
  logic push;
  logic [7:0] sdid;

  // sizing of the incoming line
  logic next_lead;
  logic [6:0] next_cap;
  logic [6:0] next_use;
  logic [7:0] next_used;
  logic [7:0] next_pad;

  // ****************************************
  // line sizing
  // ****************************************
  always_comb
  begin
    next_lead = (desc.fmt == VAPF_FMT_TTX625 || desc.fmt == VAPF_FMT_TTX525) && !desc.custom;
    next_cap = 7'((VAPF_MAX_UDW - (next_lead ? 2 : 0)) / 2);
    // excess bytes are drained, never sent, to hold the line limit
    next_use = (desc.nbytes > next_cap) ? next_cap : desc.nbytes;
    next_used = {next_use, 1'b0} + (next_lead ? 8'h02 : 8'h00);
    next_pad = (next_used + 8'h03) & 8'hfc;
  end

  // ****************************************
  // format id lookup
  // ****************************************
  always_comb
  begin
    case (line.fmt)
      VAPF_FMT_WSS: sdid = VAPF_SDID_WSS;
      VAPF_FMT_VPS: sdid = VAPF_SDID_VPS;
      VAPF_FMT_CC: sdid = line.field2 ? VAPF_SDID_CC_F2 : VAPF_SDID_CC_F1;
      VAPF_FMT_GUIDE: sdid = line.field2 ? VAPF_SDID_GD_F2 : VAPF_SDID_GD_F1;
      VAPF_FMT_TTX625:
      begin
        if (line.custom)
          sdid = line.field2 ? VAPF_SDID_T625C_F2 : VAPF_SDID_T625C_F1;
        else
          sdid = line.field2 ? VAPF_SDID_T625_F2 : VAPF_SDID_T625_F1;
      end
      VAPF_FMT_TTX525:
      begin
        if (line.custom)
          sdid = line.field2 ? VAPF_SDID_T525C_F2 : VAPF_SDID_T525C_F1;
        else
          sdid = line.field2 ? VAPF_SDID_T525_F2 : VAPF_SDID_T525_F1;
      end
      // code 02 belongs to no known format; an unknown format falls back to it only as a marker
      default: sdid = VAPF_SDID_UNUSED;
    endcase
  end

  // ****************************************
  // word source
  // ****************************************
  always_comb
  begin
    word = '0;
    word_valid = 1'b0;
    case (state)
      S_ADF:
      begin
        word.data = (idx == 2'h0) ? VAPF_ADF_FIRST : VAPF_ADF_NEXT;
        word.first = (idx == 2'h0);
        word_valid = 1'b1;
      end
      S_DID:
      begin
        word.data = vapf_protect(did_field);
        word_valid = 1'b1;
      end
      S_SDID:
      begin
        word.data = sdid;
        word_valid = 1'b1;
      end
      S_DC:
      begin
        word.data = vapf_protect(groups);
        word_valid = 1'b1;
      end
      S_LEAD:
      begin
        if (idx == 2'h0)
          word.data = vapf_protect({3'h0, line.magazine});
        else
          word.data = vapf_protect({1'b0, line.page});
        word_valid = 1'b1;
      end
      S_LO:
      begin
        // low nibble first, straight from the arriving byte
        word.data = vapf_protect({2'h0, byte_data[3:0]});
        word_valid = byte_valid;
      end
      S_HI:
      begin
        word.data = vapf_protect({2'h0, hi_nibble});
        word_valid = 1'b1;
      end
      S_FILL:
      begin
        word.data = VAPF_FILLER;
        word_valid = 1'b1;
      end
      S_CS:
      begin
        word.data = {~csum[6], csum};
        word.last = 1'b1;
        word_valid = 1'b1;
      end
      default:
      begin
        word = '0;
        word_valid = 1'b0;
      end
    endcase
  end

  assign push = word_valid & buf_ready;
  assign desc_ready = (state == S_IDLE);
  // a sent byte is taken only when its low word enters the buffer, so a stall holds the slicer; excess bytes are taken in S_DRAIN
  assign byte_ready = ((state == S_LO) && buf_ready) || ((state == S_DRAIN) && (drain_left != 7'h0));
  assign busy = (state != S_IDLE);

  // ****************************************
  // sequencing
  // ****************************************
  always_comb
  begin
    next_state = state;
    case (state)
      S_IDLE: if (desc_valid) next_state = S_WAIT;
      S_WAIT:
      begin
        // the slicer's line number decides which video line carries the packet
        if (eav_pulse && (eav_line == line.tv_line))
          next_state = S_ADF;
      end
      S_ADF: if (push && (idx == VAPF_ADF_LAST_IDX)) next_state = S_DID;
      S_DID: if (push) next_state = S_SDID;
      S_SDID: if (push) next_state = S_DC;
      S_DC:
      begin
        if (push)
        begin
          if (lead)
            next_state = S_LEAD;
          else if (bytes_left != 7'h0)
            next_state = S_LO;
          else if (fill_left != 2'h0)
            next_state = S_FILL;
          else
            next_state = S_CS;
        end
      end
      S_LEAD:
      begin
        if (push && (idx == 2'h1))
        begin
          if (bytes_left != 7'h0)
            next_state = S_LO;
          else
            next_state = S_FILL;
        end
      end
      S_LO: if (push) next_state = S_HI;
      S_HI:
      begin
        if (push)
        begin
          if (bytes_left != 7'h1)
            next_state = S_LO;
          else if (fill_left != 2'h0)
            next_state = S_FILL;
          else
            next_state = S_CS;
        end
      end
      S_FILL: if (push && (fill_left == 2'h1)) next_state = S_CS;
      S_CS: if (push) next_state = (drain_left != 7'h0) ? S_DRAIN : S_IDLE;
      S_DRAIN: if (drain_left == 7'h0) next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      state <= S_IDLE;
    else
      state <= next_state;
  end

  // ****************************************
  // line capture and control field
  // ****************************************
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      line <= '0;
      lead <= 1'b0;
      groups <= 6'h0;
      fill_left <= 2'h0;
      bytes_left <= 7'h0;
      drain_left <= 7'h0;
    end
    else if ((state == S_IDLE) && desc_valid)
    begin
      line <= desc;
      lead <= next_lead;
      groups <= next_pad[7:2];
      fill_left <= 2'(next_pad - next_used);
      bytes_left <= next_use;
      drain_left <= desc.nbytes - next_use;
    end
    else
    begin
      if ((state == S_HI) && push)
        bytes_left <= bytes_left - 7'h1;
      if ((state == S_FILL) && push)
        fill_left <= fill_left - 2'h1;
      if ((state == S_DRAIN) && byte_valid && (drain_left != 7'h0))
        drain_left <= drain_left - 7'h1;
    end
  end

  // the id field is sampled only between packets so a change never splits one
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      did_field <= VAPF_DID_RESET;
    else if (state == S_IDLE)
      did_field <= slicer_data_id_field;
  end

  // ****************************************
  // byte split and position counter
  // ****************************************
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      hi_nibble <= 4'h0;
    else if ((state == S_LO) && push)
      hi_nibble <= byte_data[7:4];
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      idx <= 2'h0;
    else if (state != next_state)
      idx <= 2'h0;
    else if (push)
      idx <= idx + 2'h1;
  end

  // ****************************************
  // checksum
  // ****************************************
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      csum <= 7'h0;
    else if (state == S_ADF)
      csum <= 7'h0;
    else if (push && (state != S_CS))
      csum <= csum + word.data[6:0];
  end

  // ****************************************
  // output buffer
  // ****************************************
  vapf_word_type buf_word;

  // two entries let a receiver stall for a cycle without a gap in the packet
  vapf_skid
  #(
    .WIDTH($bits(vapf_word_type)),
    .DEPTH(2)
  )
  u_skid
  (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .in_valid(word_valid),
    .in_ready(buf_ready),
    .in_data(word),
    .out_valid(anc_valid),
    .out_ready(anc_ready),
    .out_data(buf_word)
  );

  assign anc_data = buf_word.data;
  assign anc_first = buf_word.first;
  assign anc_last = buf_word.last;

endmodule : vapf_formatter
`default_nettype wire

// ===== vapf_formatter_sva.sv
// concurrent checks on the ports of the ancillary packet sequencer
`timescale 1ns/100ps
`default_nettype none
module vapf_formatter_sva
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // descriptor side
  input wire logic [5:0] slicer_data_id_field,
  input wire logic desc_valid,
  input wire logic desc_ready,
  input wire vapf_pkg::vapf_desc_type desc,
  // video timing
  input wire logic eav_pulse,
  input wire logic [9:0] eav_line,
  // word side
  input wire logic anc_valid,
  input wire logic anc_ready,
  input wire logic [7:0] anc_data,
  input wire logic anc_first,
  input wire logic anc_last,
  input wire logic busy
);
  import vapf_pkg::*;
  logic [6:0] idx;
  logic [6:0] sum;
  logic [5:0] did_q;
  logic [5:0] dc_q;
  logic [9:0] line_q;
  logic armed;
  logic take;
  assign take = anc_valid && anc_ready;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  // ****************************************
  // word position and running sum
  // ****************************************
  // idx is the position of the word now shown, counted from the flag
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
      idx <= 7'h0;
    else if (take)
      idx <= anc_first ? 7'h1 : idx + 7'h1;

  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
      sum <= 7'h0;
    else if (take && anc_first)
      sum <= 7'h0;
    else if (take && idx >= 7'h3 && !anc_last)
      sum <= sum + anc_data[6:0];

  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
      dc_q <= 6'h0;
    else if (take && idx == 7'h5)
      dc_q <= anc_data[5:0];

  // descriptor capture; armed until its own line's eav arrives
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
    begin
      armed <= 1'b0;
      did_q <= 6'h0;
      line_q <= 10'h0;
    end
    else if (desc_valid && desc_ready)
    begin
      armed <= 1'b1;
      did_q <= slicer_data_id_field;
      line_q <= desc.tv_line;
    end
    else if (eav_pulse && eav_line == line_q)
      armed <= 1'b0;

  // ****************************************
  // assertions
  // ****************************************
  sequence s_eav_hit;
    armed && !anc_valid && eav_pulse && eav_line == line_q;
  endsequence
  sequence s_flag_out;
    anc_valid && anc_first && anc_data == 8'h00;
  endsequence

  chk_eav_start: assert property (s_eav_hit |-> ##2 s_flag_out)
    else $error("packet did not start two cycles after its eav");
  chk_eav_other: assert property (armed && !anc_valid && eav_pulse && eav_line != line_q |=> ##1 !anc_valid)
    else $error("packet started on a foreign line");
  chk_flag_bytes: assert property (anc_valid && !anc_first && (idx == 7'h1 || idx == 7'h2) |-> anc_data == 8'hff)
    else $error("flag byte is not ff");
  chk_did_byte: assert property (anc_valid && idx == 7'h3 |-> anc_data == {~(^did_q), ^did_q, did_q})
    else $error("data id byte wrong");
  // idx still holds the last packet's length while a new flag is shown, so the flag is left out
  chk_word_parity: assert property (anc_valid && !anc_first && idx >= 7'h4 && !anc_last |-> anc_data[7] != anc_data[6] && anc_data[6] == ^anc_data[5:0])
    else $error("word parity bits wrong");
  chk_dc_bound: assert property (anc_valid && idx == 7'h5 |-> anc_data[5:0] <= 6'd23)
    else $error("group count exceeds the line budget");
  chk_pkt_length: assert property (anc_valid && anc_last |-> {1'b0, idx} == 8'd6 + {dc_q, 2'b00})
    else $error("packet length does not match group count");
  chk_cs_value: assert property (anc_valid && anc_last |-> anc_data == {~sum[6], sum})
    else $error("checksum wrong");
  chk_word_stands: assert property (anc_valid && !anc_ready |=> anc_valid && $stable(anc_data) && $stable(anc_last))
    else $error("stalled word changed");
  chk_take_busy: assert property (desc_valid && desc_ready |=> busy && !desc_ready)
    else $error("descriptor taken but sequencer idle");
endmodule : vapf_formatter_sva

bind vapf_formatter vapf_formatter_sva chk_i (.clk_sys(clk_sys), .arst_n(arst_n),
  .slicer_data_id_field(slicer_data_id_field), .desc_valid(desc_valid), .desc_ready(desc_ready), .desc(desc),
  .eav_pulse(eav_pulse), .eav_line(eav_line), .anc_valid(anc_valid), .anc_ready(anc_ready),
  .anc_data(anc_data), .anc_first(anc_first), .anc_last(anc_last), .busy(busy));
`default_nettype wire

// ===== vapf_sink.sv
// receiver model that takes ancillary words with random stalls
`timescale 1ns/100ps
`default_nettype none
module vapf_sink
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // long stall request from the bench
  input wire logic hold,
  // word stream
  input wire logic anc_valid,
  input wire logic [7:0] anc_data,
  output logic anc_ready
);
  logic [7:0] words [$];
  int seed = 71434;
  initial anc_ready = 1'b0;
  always @(negedge clk_sys)
    anc_ready <= !hold && (($random(seed) & 3) != 0);
  // fillers are stored too; they are told from data by position, never used as data
  always @(posedge clk_sys)
    if (arst_n && anc_valid && anc_ready)
      words.push_back(anc_data);
endmodule : vapf_sink
`default_nettype wire

// ===== vbi_ancillary_packet_formatter_tb.sv
// self-checking bench of the ancillary packet formatter
`timescale 1ns/100ps
`default_nettype none
module vbi_ancillary_packet_formatter_tb;
  import vapf_pkg::*;
  logic clk_sys, arst_n, desc_valid, byte_valid, eav_pulse, hold;
  logic desc_ready, byte_ready, anc_valid, anc_ready, anc_first, anc_last, busy;
  logic [5:0] did;
  logic [7:0] byte_data, anc_data;
  logic [9:0] eav_line;
  vapf_desc_type desc;
  int errors, compares, seed;
  logic [7:0] bytes [$];
  logic [7:0] exp_q [$];

  vapf_formatter dut (.clk_sys(clk_sys), .arst_n(arst_n), .slicer_data_id_field(did),
    .desc_valid(desc_valid), .desc_ready(desc_ready), .desc(desc), .byte_valid(byte_valid),
    .byte_ready(byte_ready), .byte_data(byte_data), .eav_pulse(eav_pulse), .eav_line(eav_line),
    .anc_valid(anc_valid), .anc_ready(anc_ready), .anc_data(anc_data), .anc_first(anc_first),
    .anc_last(anc_last), .busy(busy));
  vapf_sink snk (.clk_sys(clk_sys), .arst_n(arst_n), .hold(hold), .anc_valid(anc_valid),
    .anc_data(anc_data), .anc_ready(anc_ready));

  // ****************************************
  // expectations
  // ****************************************
  function automatic logic [7:0] pr(input logic [5:0] v);
    return {~(^v), ^v, v};
  endfunction : pr

  function automatic logic [7:0] sdid_of(input vapf_desc_type d);
    case (d.fmt)
      VAPF_FMT_WSS: return 8'h41;
      VAPF_FMT_VPS: return 8'h83;
      VAPF_FMT_CC: return d.field2 ? 8'h44 : 8'h85;
      VAPF_FMT_GUIDE: return d.field2 ? 8'h86 : 8'h47;
      VAPF_FMT_TTX625: return d.custom ? (d.field2 ? 8'h8a : 8'h4b) : (d.field2 ? 8'h48 : 8'h89);
      VAPF_FMT_TTX525: return d.custom ? (d.field2 ? 8'h92 : 8'h53) : (d.field2 ? 8'h50 : 8'h91);
      default: return 8'h42;
    endcase
  endfunction : sdid_of

  task automatic build(input vapf_desc_type d);
    logic [7:0] u [$];
    logic [6:0] s;
    bit ttx;
    ttx = (d.fmt == VAPF_FMT_TTX625 || d.fmt == VAPF_FMT_TTX525) && !d.custom;
    if (ttx)
      u = {pr({3'h0, d.magazine}), pr({1'h0, d.page})};
    // the line budget caps user words at 92
    foreach (bytes[i])
      if (i < (ttx ? 45 : 46))
        u = {u, pr({2'h0, bytes[i][3:0]}), pr({2'h0, bytes[i][7:4]})};
    while (u.size() % 4 != 0)
      u.push_back(8'h80);
    exp_q = {8'h00, 8'hff, 8'hff, pr(did), sdid_of(d), pr(6'(u.size() / 4)), u};
    s = 7'h0;
    for (int i = 3; i < exp_q.size(); i++)
      s += exp_q[i][6:0];
    exp_q.push_back({~s[6], s});
  endtask : build

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    if (errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  // ****************************************
  // one packet: descriptor, foreign eav, own eav, bytes
  // ****************************************
  task automatic run_pkt(input vapf_fmt_type f, input logic f2, input logic cu, input int n, input logic stall);
    vapf_desc_type d;
    d = {f, f2, cu, 10'($random(seed)), 3'($random(seed)), 5'($random(seed)), 7'(n)};
    bytes.delete();
    repeat (n) bytes.push_back(8'($random(seed)));
    build(d);
    snk.words.delete();
    desc = d;
    desc_valid = 1'b1;
    #1;
    while (!desc_ready) @(negedge clk_sys);
    @(negedge clk_sys);
    desc_valid = 1'b0;
    hold = stall;
    fork
      begin
        eav_line = d.tv_line + 10'h1;
        eav_pulse = 1'b1;
        @(negedge clk_sys);
        eav_pulse = 1'b0;
        repeat (3) @(negedge clk_sys);
        eav_line = d.tv_line;
        eav_pulse = 1'b1;
        @(negedge clk_sys);
        eav_pulse = 1'b0;
        // a long stall fills the buffer so the byte port must refuse
        repeat (40) @(negedge clk_sys);
        hold = 1'b0;
      end
      begin
        foreach (bytes[i])
        begin
          byte_data = bytes[i];
          byte_valid = 1'b1;
          #1;
          while (!byte_ready) @(negedge clk_sys);
          @(negedge clk_sys);
        end
        byte_valid = 1'b0;
      end
    join
    while (busy || anc_valid) @(negedge clk_sys);
    check(8'(snk.words.size()), 8'(exp_q.size()));
    foreach (exp_q[i]) check(snk.words[i], exp_q[i]);
  endtask : run_pkt

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  initial
  begin
    #1000000;
    errors++;
    tally_and_finish();
  end

  // every format, field and frame code, then a capped line and an unknown format
  initial
  begin
    vapf_fmt_type f;
    int n;
    seed = 71434;
    errors = 0;
    compares = 0;
    {desc_valid, byte_valid, eav_pulse, hold} = 4'h0;
    desc = '0;
    byte_data = 8'h00;
    eav_line = 10'h000;
    did = 6'h01;
    arst_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    arst_n = 1'b1;
    for (int k = 0; k < 26; k++)
    begin
      if (k > 0)
        did = 6'($random(seed));
      @(negedge clk_sys);
      f = vapf_fmt_type'(k < 24 ? k / 4 : (k == 24 ? 0 : 6));
      n = (f == VAPF_FMT_TTX625) ? 40 : (f == VAPF_FMT_TTX525) ? 32 : 1 + ($random(seed) & 7);
      if (k[1] && n >= 32)
        n += 2;
      if (k == 24)
        n = 50;
      run_pkt(f, k[0], k[1], n, k % 5 == 2);
    end
    tally_and_finish();
  end
endmodule : vbi_ancillary_packet_formatter_tb
`default_nettype wire
